// *** asc_top.sv ***
// Converter sequencing controller: registers, trigger, sweep and interrupt
//
// Overview of operation
// - One-shot and single sweep end raise flag.
// - Repeat modes with transfer mode flag each.
// - Stop leaves results undefined, flagged.
// - External trigger ignored in transfer mode.
// - Stopping single sweep may raise flag.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module asc_top (
   input  wire logic        i_clock,
   input  wire logic        i_resetn,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_ext_trigger_n,
   input  wire logic        i_hw_trigger,
   input  wire logic [9:0]  i_conv_result,
   output logic [31:0]      o_rdata,
   output logic             o_irq,
   output logic [2:0]       o_conv_channel,
   output logic             o_conv_sample,
   output logic             o_ref_disconnect,
   output logic             o_dma_req,
   output logic             o_busy
);
   logic [7:0]                     ctrl_a_q, ctrl_b_q;
   logic                           dus_q, start_q;
   logic [asc_pkg::STAT_W-1:0]     stat_q, mask_q;
   logic [asc_pkg::RES_W-1:0]      res_q [asc_pkg::NCH];
   asc_pkg::asc_state_t            state_q;
   logic [2:0]                     ch_q;
   logic [4:0]                     tick_cnt_q;
   logic [5:0]                     div_cnt_q;
   logic [6:0]                     settle_q;
   logic                           ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
   logic                           tick, done, conv_go, trig_ev, ext_fall;
   logic                           abort, wr_a, wr_st, sweep, last_ch;
   logic [2:0]                     mode;
   logic [2:0]                     first_ch;

   // Highest channel of a sweep group
   function automatic logic [2:0] sweep_last(input logic [1:0] scan);
      sweep_last = {scan, 1'b1};
   endfunction

   // Converter clock divider terminal count for a select value
   function automatic logic [5:0] div_max(input logic [1:0] sel);
      div_max = 6'(asc_pkg::DIV_BASE << sel) - 6'h01;
   endfunction

   assign mode    = {ctrl_b_q[asc_pkg::B_MD2], ctrl_a_q[asc_pkg::A_MD1],
                     ctrl_a_q[asc_pkg::A_MD0]};
   assign sweep   = (mode != asc_pkg::MODE_ONESHOT) && (mode != asc_pkg::MODE_REPEAT);
   assign first_ch = sweep ? 3'h0 : ctrl_a_q[asc_pkg::A_CH_LO +: 3];
   assign last_ch = (ch_q == sweep_last(ctrl_b_q[asc_pkg::B_SCAN_LO +: 2]));
   assign wr_a    = i_wr && (i_addr == asc_pkg::OFF_CTRL_A);
   assign wr_st   = i_wr && (i_addr == asc_pkg::OFF_STATUS);
   // Software stop: start bit written to zero while the sequencer is active
   assign abort   = wr_a && !i_wdata[asc_pkg::A_START] && (state_q != asc_pkg::ST_IDLE);
   assign tick    = (div_cnt_q == div_max(ctrl_b_q[asc_pkg::B_DIV_LO +: 2]));
   assign done    = (state_q == asc_pkg::ST_CONV) && tick && !abort
                    && (tick_cnt_q == 5'(asc_pkg::CONV_TICKS - 1));
   // Falling edge of the filtered pin; the pin is unusable in transfer mode
   assign ext_fall = ext_lvl_q && (ext_s2_q == ext_s3_q) && !ext_s3_q;
   assign trig_ev = ctrl_a_q[asc_pkg::A_TSRC] ? i_hw_trigger
                                              : (ext_fall && !dus_q);
   // Start needs the reference settled after a disconnect
   assign conv_go = !abort && (settle_q == 7'h00) && start_q &&
                    (((state_q == asc_pkg::ST_IDLE) && !ctrl_a_q[asc_pkg::A_TRG]) ||
                     ((state_q == asc_pkg::ST_ARMED) && trig_ev));

   // External trigger pin synchroniser and agreement filter
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         ext_s1_q  <= 1'b1;
         ext_s2_q  <= 1'b1;
         ext_s3_q  <= 1'b1;
         ext_lvl_q <= 1'b1;
      end else begin
         ext_s1_q <= i_ext_trigger_n;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         if (ext_s2_q == ext_s3_q) begin
            ext_lvl_q <= ext_s3_q;
         end
      end
   end

   // Configuration registers; software keeps them still while running
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_a_q <= asc_pkg::CTRL_RST;
         ctrl_b_q <= asc_pkg::CTRL_RST;
         dus_q    <= 1'b0;
         mask_q   <= '0;
      end else if (i_wr) begin
         unique case (i_addr)
            asc_pkg::OFF_CTRL_A: ctrl_a_q <= i_wdata[7:0];
            asc_pkg::OFF_CTRL_B: ctrl_b_q <= i_wdata[7:0];
            asc_pkg::OFF_CTRL_D: dus_q    <= i_wdata[asc_pkg::D_DUS];
            asc_pkg::OFF_MASK:   mask_q   <= i_wdata[asc_pkg::STAT_W-1:0];
            default: ;
         endcase
      end
   end

   // Start bit: set or cleared by software, cleared when a sequence ends
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         start_q <= 1'b0;
      end else if (wr_a) begin
         start_q <= i_wdata[asc_pkg::A_START];
      end else if (done && (mode == asc_pkg::MODE_ONESHOT ||
                            (mode == asc_pkg::MODE_SSWEEP && last_ch))) begin
         start_q <= 1'b0;
      end
   end

   // Reference settle counter, reloaded on a connected to disconnected change
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         settle_q <= 7'h00;
      end else if (i_wr && (i_addr == asc_pkg::OFF_CTRL_B) &&
                   i_wdata[asc_pkg::B_REFERENCE_DISCONNECT] && !ctrl_b_q[asc_pkg::B_REFERENCE_DISCONNECT]) begin
         settle_q <= 7'(asc_pkg::REF_SETTLE_CYC);
      end else if (settle_q != 7'h00) begin
         settle_q <= settle_q - 7'h01;
      end
   end

   // Converter clock divider, free running
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         div_cnt_q <= 6'h00;
      end else if (tick) begin
         div_cnt_q <= 6'h00;
      end else begin
         div_cnt_q <= div_cnt_q + 6'h01;
      end
   end

   // Sequencer: idle, waiting for a trigger, converting
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q    <= asc_pkg::ST_IDLE;
         ch_q       <= 3'h0;
         tick_cnt_q <= 5'h00;
      end else if (abort || (wr_a && !i_wdata[asc_pkg::A_START])) begin
         state_q <= asc_pkg::ST_IDLE;
      end else if (conv_go) begin
         state_q    <= asc_pkg::ST_CONV;
         ch_q       <= first_ch;
         tick_cnt_q <= 5'h00;
      end else begin
         unique case (state_q)
            asc_pkg::ST_IDLE: begin
               if (start_q && ctrl_a_q[asc_pkg::A_TRG]) begin
                  state_q <= asc_pkg::ST_ARMED;
               end
            end
            asc_pkg::ST_ARMED: ;
            asc_pkg::ST_CONV: begin
               if (tick) begin
                  tick_cnt_q <= done ? 5'h00 : tick_cnt_q + 5'h01;
               end
               if (done) begin
                  if (mode == asc_pkg::MODE_ONESHOT ||
                      (mode == asc_pkg::MODE_SSWEEP && last_ch)) begin
                     state_q <= asc_pkg::ST_IDLE;
                  end else if (sweep) begin
                     ch_q <= last_ch ? 3'h0 : ch_q + 3'h1;
                  end
               end
            end
         endcase
      end
   end

   // Result store into the register of the converted channel
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int i = 0; i < asc_pkg::NCH; i++) begin
            res_q[i] <= '0;
         end
      end else if (done) begin
         res_q[ch_q] <= i_conv_result;
      end
   end

   // Sticky status; hardware set wins over a write-one clear
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         stat_q <= '0;
      end else begin
         stat_q[asc_pkg::S_DONE] <= (stat_q[asc_pkg::S_DONE] &&
            !(wr_st && i_wdata[asc_pkg::S_DONE])) ||
            (done && (mode == asc_pkg::MODE_ONESHOT ||
             (mode == asc_pkg::MODE_SSWEEP && last_ch) || dus_q)) ||
            (abort && mode == asc_pkg::MODE_SSWEEP);
         stat_q[asc_pkg::S_ABORT] <= (stat_q[asc_pkg::S_ABORT] &&
            !(wr_st && i_wdata[asc_pkg::S_ABORT])) || abort;
      end
   end

   // Outputs toward the analog macro, transfer engine and interrupt line
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_irq            <= 1'b0;
         o_conv_channel   <= 3'h0;
         o_conv_sample    <= 1'b0;
         o_ref_disconnect <= 1'b0;
         o_dma_req        <= 1'b0;
         o_busy           <= 1'b0;
      end else begin
         o_irq            <= |(stat_q & mask_q);
         o_conv_channel   <= conv_go ? first_ch : ch_q;
         o_conv_sample    <= conv_go || (done && state_q == asc_pkg::ST_CONV &&
                             !(mode == asc_pkg::MODE_ONESHOT ||
                               (mode == asc_pkg::MODE_SSWEEP && last_ch)));
         o_ref_disconnect <= ctrl_b_q[asc_pkg::B_REFERENCE_DISCONNECT];
         o_dma_req        <= done && dus_q;
         o_busy           <= (state_q == asc_pkg::ST_CONV) || conv_go;
      end
   end

   // Read port: data stands in the cycle after the strobe only
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 32'h0;
      end else if (!i_rd) begin
         o_rdata <= 32'h0;
      end else if (i_addr >= asc_pkg::OFF_RESULT && i_addr <= asc_pkg::OFF_RES_END
                   && i_addr[1:0] == 2'h0) begin
         o_rdata <= 32'(res_q[i_addr[4:2]]);
      end else begin
         unique case (i_addr)
            asc_pkg::OFF_CTRL_A: o_rdata <= 32'({ctrl_a_q[7], start_q, ctrl_a_q[5:0]});
            asc_pkg::OFF_CTRL_B: o_rdata <= 32'(ctrl_b_q);
            asc_pkg::OFF_CTRL_D: o_rdata <= 32'(dus_q);
            asc_pkg::OFF_STATUS: o_rdata <= 32'(stat_q);
            asc_pkg::OFF_MASK:   o_rdata <= 32'(mask_q);
            default:             o_rdata <= 32'h0;
         endcase
      end
   end

   // Checks
   sequence s_stop;
      abort;
   endsequence
   sequence s_sweep_stop;
      abort && (mode == asc_pkg::MODE_SSWEEP);
   endsequence

   a_oneshot_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
      done && mode == asc_pkg::MODE_ONESHOT |=> stat_q[asc_pkg::S_DONE] && !start_q
         ##1 o_irq == mask_q[asc_pkg::S_DONE])
      else $error("one-shot end did not raise flag");
   a_repeat_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
      done && dus_q && mode == asc_pkg::MODE_REPEAT |=> stat_q[asc_pkg::S_DONE] && o_dma_req)
      else $error("transfer mode conversion did not flag");
   a_stop_undef: assert property (@(posedge i_clock) disable iff (!i_resetn)
      s_stop |=> stat_q[asc_pkg::S_ABORT] && state_q == asc_pkg::ST_IDLE)
      else $error("stop did not mark results undefined");
   a_sweep_stop: assert property (@(posedge i_clock) disable iff (!i_resetn)
      s_sweep_stop |=> stat_q[asc_pkg::S_DONE])
      else $error("single sweep stop did not raise flag");
   a_ext_ignored: assert property (@(posedge i_clock) disable iff (!i_resetn)
      state_q == asc_pkg::ST_ARMED && dus_q && !ctrl_a_q[asc_pkg::A_TSRC] && !i_wr
         |=> state_q == asc_pkg::ST_ARMED)
      else $error("external trigger used in transfer mode");
   a_settle_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
      $rose(o_ref_disconnect) |-> !o_busy [*8])
      else $error("conversion started before reference settled");
   a_result_store: assert property (@(posedge i_clock) disable iff (!i_resetn)
      done |=> res_q[$past(ch_q)] == $past(i_conv_result))
      else $error("result not stored in its channel");
   a_soft_start: assert property (@(posedge i_clock) disable iff (!i_resetn)
      state_q == asc_pkg::ST_IDLE && start_q && !ctrl_a_q[asc_pkg::A_TRG] && !i_wr
         && settle_q == 7'h00 |=> state_q == asc_pkg::ST_CONV ##1 o_busy)
      else $error("start bit did not begin conversion");
   a_conv_length: assert property (@(posedge i_clock) disable iff (!i_resetn)
      $rose(o_busy) && !i_wr [*1] |-> o_busy [*3])
      else $error("conversion ended too early");
endmodule // asc_top

// *** asc_pkg.sv ***
// Shared constants of the converter sequencing controller
package asc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL_A  = 8'h00;
   localparam logic [7:0] OFF_CTRL_B  = 8'h04;
   localparam logic [7:0] OFF_CTRL_D  = 8'h08;
   localparam logic [7:0] OFF_STATUS  = 8'h0c;
   localparam logic [7:0] OFF_MASK    = 8'h10;
   localparam logic [7:0] OFF_RESULT  = 8'h20; // Eight words, one per channel
   localparam logic [7:0] OFF_RES_END = 8'h3c;
   // conv_control_a fields
   localparam int A_CH_LO   = 0;  // channel_sel_bit2..0
   localparam int A_MD0     = 3;  // op_mode_bit0
   localparam int A_MD1     = 4;  // op_mode_bit1
   localparam int A_TRG     = 5;  // trigger_select
   localparam int A_START   = 6;  // conv_start_bit
   localparam int A_TSRC    = 7;  // 0 external pin, 1 hardware trigger
   // conv_control_b fields
   localparam int B_SCAN_LO = 0;  // sweep_range_bit1..0
   localparam int B_MD2     = 2;  // op_mode_bit2
   localparam int B_REFERENCE_DISCONNECT    = 3;  // reference_disconnect
   localparam int B_SH      = 4;  // Sample-and-hold enable
   localparam int B_DIV_LO  = 5;  // Converter clock divider select, 2 bits
   // conv_control_d fields
   localparam int D_DUS     = 0;  // transfer_engine_mode
   // Status and mask layout
   localparam int S_DONE    = 0;  // irq_request_flag
   localparam int S_ABORT   = 1;  // Results left undefined by a stop
   localparam int STAT_W    = 2;
   // Widths and reset values
   localparam int RES_W     = 10;
   localparam int NCH       = 8;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Operating modes, encoded as {op_mode_bit2, op_mode_bit1, op_mode_bit0}
   localparam logic [2:0] MODE_ONESHOT = 3'h0;
   localparam logic [2:0] MODE_REPEAT  = 3'h1;
   localparam logic [2:0] MODE_SSWEEP  = 3'h2;
   localparam logic [2:0] MODE_RSWEEP0 = 3'h3;
   localparam logic [2:0] MODE_RSWEEP1 = 3'h7;
   // Timing
   localparam int CLK_NS        = 20;
   localparam int REF_SETTLE_NS = 1000;
   localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_TICKS    = 17; // Converter clock cycles per result
   localparam int DIV_BASE      = 4;  // Smallest division keeps it under 16 MHz
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} asc_state_t;
endpackage

// *** asc_far_model.sv ***
// Far side model: analog result source and external trigger pin
`timescale 1ns/1ps
module asc_far_model (
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   input  wire logic [2:0] i_channel,
   input  wire logic       i_busy,
   input  wire logic       i_fire,
   input  wire logic [9:0] i_key,
   output logic [9:0]      o_result,
   output logic            o_trigger_n
);
   logic [9:0] noise_q;
   logic [2:0] low_q;
   // Analog value per channel while converting, noise at any other time
   assign o_result = i_busy ? (i_key ^ {i_channel, 4'h0, i_channel}) : noise_q;
   // Pin idles high and is pulled low four cycles per fire request
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         noise_q <= 10'h000;
         low_q   <= 3'h0;
      end else begin
         noise_q <= noise_q + 10'h0f3;
         low_q   <= i_fire ? 3'h4 : ((low_q != 3'h0) ? low_q - 3'h1 : 3'h0);
      end
   end
   assign o_trigger_n = (low_q == 3'h0);
endmodule // asc_far_model

// *** testbench.sv ***
// Self-checking bench of the converter sequencing controller
`timescale 1ns/1ps
module testbench;
   logic        i_clock, i_resetn, i_wr, i_rd, i_hw_trigger, fire, ext_n;
   logic        o_irq, o_conv_sample, o_ref_disconnect, o_dma_req, o_busy;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic [9:0]  key, conv_res;
   logic [2:0]  o_conv_channel, mode;
   integer      num_errors = 0;
   integer      num_checks = 0;
   integer      dma_cnt = 0;
   integer      smp_cnt = 0;
   integer      base;
   integer      seed = 32'hcf66;
   integer      ch, m;
   integer      exp_q[$];
   asc_top dut_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_ext_trigger_n(ext_n), .i_hw_trigger(i_hw_trigger),
      .i_conv_result(conv_res), .o_rdata(o_rdata), .o_irq(o_irq),
      .o_conv_channel(o_conv_channel), .o_conv_sample(o_conv_sample),
      .o_ref_disconnect(o_ref_disconnect), .o_dma_req(o_dma_req), .o_busy(o_busy));
   asc_far_model far_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_channel(o_conv_channel),
      .i_busy(o_busy), .i_fire(fire), .i_key(key), .o_result(conv_res), .o_trigger_n(ext_n));
   // 50 MHz clock
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   // Transfer requests and sample pulses counted as the far side sees them
   always @(posedge i_clock) begin
      if (o_dma_req === 1'b1) dma_cnt = dma_cnt + 1;
      if (o_conv_sample === 1'b1) smp_cnt = smp_cnt + 1;
   end
   task automatic end_sim;
      if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Expected analog value of a channel
   function automatic logic [31:0] ref_val(input integer c);
      return {22'h0, key ^ {c[2:0], 4'h0, c[2:0]}};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr    <= 1'b0;
   endtask
   // Read one word; the data stand only in the cycle after the strobe
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clock);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd   <= 1'b0;
      #1;
      chk(nm, o_rdata, e);
   endtask
   task automatic settle(input integer n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   // Bounded wait: 0 irq high, 1 busy equal to want, 2 transfer count reached
   task automatic wait_for(input integer kind, input integer want);
      integer n;
      for (n = 0; n < 3000; n = n + 1) begin
         settle(1);
         if ((kind == 0 && o_irq === 1'b1) || (kind == 1 && o_busy === want[0]) ||
             (kind == 2 && dma_cnt >= want)) break;
      end
      if (n == 3000) begin
         chk("wait bound", 32'h1, 32'h0);
         end_sim;
      end
   endtask
   task automatic trig(input logic hw);
      @(posedge i_clock);
      fire         <= ~hw;
      i_hw_trigger <= hw;
      @(posedge i_clock);
      fire         <= 1'b0;
      i_hw_trigger <= 1'b0;
   endtask
   // Wait for the flag, check status and every queued result, then clear
   task automatic finish(input logic [31:0] st);
      integer c;
      wait_for(0, 0);
      rdc("status", asc_pkg::OFF_STATUS, st);
      while (exp_q.size() > 0) begin
         c = exp_q.pop_front();
         rdc("result", asc_pkg::OFF_RESULT + 8'(4 * c), ref_val(c));
      end
      wr(asc_pkg::OFF_STATUS, 32'h3);
   endtask
   initial begin
      i_resetn     = 1'b0;
      i_wr         = 1'b0;
      i_rd         = 1'b0;
      i_hw_trigger = 1'b0;
      fire         = 1'b0;
      i_addr       = 8'h00;
      i_wdata      = 32'h0;
      key          = 10'($random(seed));
      repeat (10) @(posedge i_clock);
      i_resetn <= 1'b1;
      // Reset words, an unmapped word, and a control readback
      for (m = 0; m < 5; m = m + 1) rdc("reset word", 8'(4 * m), 32'h0);
      wr(8'h14, 32'hffffffff);
      rdc("unmapped", 8'h14, 32'h0);
      wr(asc_pkg::OFF_CTRL_B, 32'h13);
      rdc("ctrl_b", asc_pkg::OFF_CTRL_B, 32'h13);
      // Divider 0 keeps the converter clock at 12.5 MHz, sample-hold on
      wr(asc_pkg::OFF_CTRL_B, 32'h10);
      // Masked one-shot: no interrupt until unmasked
      ch = $random(seed) & 7;
      wr(asc_pkg::OFF_CTRL_A, 32'h40 | 32'(ch));
      exp_q.push_back(ch);
      wait_for(1, 1);
      wait_for(1, 0);
      settle(3);
      chk("masked irq", {31'h0, o_irq}, 32'h0);
      rdc("start cleared", asc_pkg::OFF_CTRL_A, 32'(ch));
      wr(asc_pkg::OFF_MASK, 32'h3);
      settle(2);
      chk("irq", {31'h0, o_irq}, 32'h1);
      finish(32'h1);
      settle(2);
      chk("irq cleared", {31'h0, o_irq}, 32'h0);
      // One-shot on every channel, fresh analog pattern each time
      for (ch = 0; ch < 8; ch = ch + 1) begin
         key <= 10'($random(seed));
         wr(asc_pkg::OFF_CTRL_A, 32'h40 | 32'(ch));
         exp_q.push_back(ch);
         finish(32'h1);
      end
      // Start just after disconnecting the reference is held off
      wr(asc_pkg::OFF_CTRL_B, 32'h08);
      wr(asc_pkg::OFF_CTRL_A, 32'h42);
      exp_q.push_back(2);
      settle(40);
      chk("ref", {31'h0, o_ref_disconnect}, 32'h1);
      chk("held off", {31'h0, o_busy}, 32'h0);
      finish(32'h1);
      // Sweep at divider 1, 6.25 MHz, range written before the mode
      wr(asc_pkg::OFF_CTRL_B, 32'h21);
      base = smp_cnt;
      wr(asc_pkg::OFF_CTRL_A, 32'h50);
      for (ch = 0; ch < 4; ch = ch + 1) exp_q.push_back(ch);
      finish(32'h1);
      chk("sample pulses", 32'(smp_cnt - base), 32'h4);
      // Single sweep stopped during its first conversion, divider 3 at 1.5625 MHz
      wr(asc_pkg::OFF_CTRL_B, 32'h63);
      wr(asc_pkg::OFF_CTRL_A, 32'h50);
      wait_for(1, 1);
      wr(asc_pkg::OFF_CTRL_A, 32'h10);
      rdc("stop status", asc_pkg::OFF_STATUS, 32'h3);
      wr(asc_pkg::OFF_STATUS, 32'h3);
      // Repeat modes with transfer requests, each stopped after three
      wr(asc_pkg::OFF_CTRL_D, 32'h1);
      for (m = 0; m < 3; m = m + 1) begin
         mode = (m == 0) ? asc_pkg::MODE_REPEAT :
                (m == 1) ? asc_pkg::MODE_RSWEEP0 : asc_pkg::MODE_RSWEEP1;
         wr(asc_pkg::OFF_CTRL_B, {29'h0, mode[2], 2'h0});
         base = dma_cnt;
         wr(asc_pkg::OFF_CTRL_A, {25'h0, 2'h2, mode[1:0], 3'h0});
         wait_for(2, base + 1);
         rdc("first result", asc_pkg::OFF_RESULT, ref_val(0));
         wait_for(2, base + 3);
         rdc("repeat status", asc_pkg::OFF_STATUS, 32'h1);
         wr(asc_pkg::OFF_CTRL_A, {27'h0, mode[1:0], 3'h0});
         rdc("abort status", asc_pkg::OFF_STATUS, 32'h3);
         wr(asc_pkg::OFF_STATUS, 32'h3);
      end
      // External trigger has no effect in transfer mode; divider 2 from here on
      wr(asc_pkg::OFF_CTRL_B, 32'h40);
      wr(asc_pkg::OFF_CTRL_A, 32'h60);
      trig(1'b0);
      settle(150);
      chk("ext ignored", {31'h0, o_busy}, 32'h0);
      wr(asc_pkg::OFF_CTRL_A, 32'h20);
      wr(asc_pkg::OFF_STATUS, 32'h3);
      wr(asc_pkg::OFF_CTRL_D, 32'h0);
      // Armed start, then external pin or hardware trigger
      for (m = 0; m < 2; m = m + 1) begin
         wr(asc_pkg::OFF_CTRL_A, (m == 1) ? 32'he3 : 32'h66);
         settle(20);
         chk("armed idle", {31'h0, o_busy}, 32'h0);
         trig(m[0]);
         exp_q.push_back((m == 1) ? 3 : 6);
         finish(32'h1);
      end
      end_sim;
   end
endmodule // testbench
